/* File: core/sct_pkg.sv */
// shared constants, register map and carrier types for the conversion timing control
`default_nettype none
package sct_pkg;
	// register byte offsets on the control bus
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_ACQ_LOW  = 8'h04;
	localparam logic [7:0] OFF_ACQ_HIGH = 8'h08;
	localparam logic [7:0] OFF_HW_OWN   = 8'h0c;
	localparam logic [7:0] OFF_FW_SW    = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_RESULT   = 8'h18;
	localparam logic [7:0] OFF_CHAN     = 8'h20;
	// field positions
	localparam int ACQ_HI_POS  = 16;
	localparam int DIV_POS     = 8;
	// reset values
	localparam logic [31:0] RST_CTRL    = 32'h0000_0100;
	localparam logic [9:0]  RST_ACQ     = 10'h004;
	localparam logic [15:0] RST_HW_OWN  = 16'hffff;
	localparam logic [15:0] RST_FW_SW   = 16'h0000;
	// cycle counts in converter clocks
	localparam logic [9:0]  ACQ_MIN     = 10'h004;
	localparam logic [4:0]  RES_FULL    = 5'd12;
	localparam logic [4:0]  RES_MID     = 5'd10;
	localparam logic [4:0]  RES_LOW     = 5'd8;
	localparam logic [4:0]  CONV_EXTRA  = 5'd2;
	// negative input choices and bus response codes
	localparam logic [1:0]  NEG_VSSA    = 2'h0;
	localparam logic [1:0]  NEG_VREF    = 2'h1;
	localparam logic [1:0]  NEG_PIN     = 2'h2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// per-channel setup word, low ten bits of a channel register
	typedef struct packed {
		logic [2:0] pin;
		logic       enable;
		logic [1:0] negSel;
		logic       diff;
		logic       altRes;
		logic [1:0] acqSel;
	} sct_chan_t;

	// global control word, low sixteen bits of the control register
	typedef struct packed {
		logic [7:0] clkDiv;
		logic [2:0] spare;
		logic       leftAlign;
		logic       signedDiff;
		logic       signedSe;
		logic       alt10;
		logic       scanEn;
	} sct_ctrl_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ  = 2'b01,
		ST_CONV = 2'b10
	} sct_state_t;
endpackage : sct_pkg
`default_nettype wire

/* File: core/sct_clk_div.sv */
// integer divider giving a one-cycle converter clock enable
`default_nettype none
module sct_clk_div #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] divisor,
	output logic              tick
);
	logic [W-1:0] cntFf;
	logic [W-1:0] nxt_cnt;
	logic         nxt_tick;

	// divide by divisor, zero treated as one; only whole ratios, no fraction
	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt  = cntFf + W'(1);
		if (cntFf + W'(1) >= divisor) begin
			nxt_cnt  = '0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			cntFf <= '0;
			tick  <= 1'b0;
		end else begin
			cntFf <= nxt_cnt;
			tick  <= nxt_tick;
		end
	end
endmodule : sct_clk_div
`default_nettype wire

/* File: core/sct_conv_ctrl.sv */
// conversion timing, result formatting, router ownership and register slave
// Overview of operation
// - vssa negative input: signed select ignored, result only 0x000 to 0x7ff
// - unsigned: top code at +full scale, 0x800 at zero, 0 at -full scale
// - signed: 0x7ff at +full scale, zero at zero, 0x800 at -full scale
// - 12-bit default; per channel one alternate, globally 8 or 10 bit
// - conversion lasts resolution plus two converter clocks, 14 at 12 bit
// - full cycle is acquisition plus resolution plus two clocks
// - four global acquisition durations, 4 to 1023 clocks, in two paired registers
// - on acquisition expiry disconnect the input and convert the held sample
// - one converter clock passes before the start strobe rises
// - acquisition-done pulse to the fabric at end of acquisition
// - default four-clock acquisition gives 18 clocks at 12 bit
// - sequencer and fabric switch control is hardware, maskable per switch
// - sequencer steps enabled channels round robin without processor help
// - sequencer reaches adjacent-pin pairs only; others need firmware or fabric
// - firmware switch bits directly set every router switch
// - signed results sign-extend to 16 bits, unsigned ones zero-extend
// - left alignment at reduced resolution zeroes the unused low bits
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`default_nettype none
module sct_conv_ctrl #(
	parameter int NCH = 4
) (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [11:0] coreCode,
	input  wire logic [15:0] fabricSw,
	input  wire logic        fabricOwn,
	output logic [15:0]      routerSw,
	output logic             sampleConnect,
	output logic             socStrobe,
	output logic             acqDone,
	output logic [15:0]      resultData,
	output logic             resultValid
);
	sct_pkg::sct_ctrl_t ctrlFf, nxt_ctrl;
	sct_pkg::sct_chan_t chanFf [NCH];
	sct_pkg::sct_chan_t nxt_chan [NCH];
	sct_pkg::sct_state_t stateFf, nxt_state;
	logic [9:0]  acqFf [4];
	logic [9:0]  nxt_acq [4];
	logic [15:0] hwOwnFf, nxt_hwOwn, fwSwFf, nxt_fwSw, seqSw, nxt_router;
	logic [9:0]  cntFf, nxt_cnt;
	logic [$clog2(NCH)-1:0] chFf, nxt_ch;
	logic [3:0]  fmtFf, nxt_fmt;
	logic [15:0] nxt_result;
	logic        nxt_sample, nxt_soc, nxt_acqDone, nxt_resValid;
	logic        tick, anyEn;
	logic [4:0]  resLen;
	logic [7:0]  awAddrFf, nxt_awAddr;
	logic [31:0] wDataFf, nxt_wData;
	logic        awHeldFf, nxt_awHeld, wHeldFf, nxt_wHeld;
	logic [1:0]  nxt_bresp, nxt_rresp;
	logic        nxt_bvalid, nxt_rvalid;
	logic [31:0] nxt_rdata;
	logic        doWrite, wrHit;
	sct_pkg::sct_chan_t cur;

	sct_clk_div #(.W(8)) uDiv (
		.clock   (clock),
		.rst_b   (rst_b),
		.divisor (ctrlFf.clkDiv),
		.tick    (tick)
	);

	assign cur    = chanFf[chFf];
	// alternate resolution is one global choice, picked per channel
	assign resLen = !cur.altRes ? sct_pkg::RES_FULL :
		(ctrlFf.alt10 ? sct_pkg::RES_MID : sct_pkg::RES_LOW);

	// place the code msb-first in 12 bits, then encode and align
	function automatic logic [15:0] fmtCode(input logic [11:0] raw, input logic [4:0] res,
			input logic vssa, input logic sgn, input logic left);
		logic [11:0] top;
		logic [3:0]  sh;
		sh  = 4'(sct_pkg::RES_FULL - res);
		top = raw << sh;
		if (vssa) begin
			top = top[11] ? {1'b0, top[10:0]} : 12'h000;
		end else if (sgn) begin
			top[11] = ~top[11];
		end
		if (left) begin
			fmtCode = {top, 4'h0};
		end else if (sgn && !vssa) begin
			fmtCode = 16'($signed({top, 4'h0}) >>> (5'd4 + 5'(sh)));
		end else begin
			fmtCode = {4'h0, top} >> sh;
		end
	endfunction : fmtCode

	// sequencer only reaches a pin and its even/odd neighbour
	always_comb begin
		seqSw = '0;
		seqSw[cur.pin] = 1'b1;
		if (cur.negSel == sct_pkg::NEG_PIN) begin
			seqSw[8 + 32'(cur.pin ^ 3'h1)] = 1'b1;
		end
	end

	// per-switch owner: hardware (fabric or sequencer) unless masked to firmware
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : gSw
			assign nxt_router[gi] = hwOwnFf[gi] ? (fabricOwn ? fabricSw[gi] : seqSw[gi])
				: fwSwFf[gi];
		end
	endgenerate

	// timing sequence: acquisition then resolution plus two conversion clocks
	always_comb begin
		nxt_state    = stateFf;
		nxt_cnt      = cntFf;
		nxt_ch       = chFf;
		nxt_fmt      = fmtFf;
		nxt_result   = resultData;
		nxt_sample   = sampleConnect;
		nxt_soc      = 1'b0;
		nxt_acqDone  = 1'b0;
		nxt_resValid = 1'b0;
		anyEn        = 1'b0;
		for (int i = 0; i < NCH; i++) begin
			anyEn = anyEn | chanFf[i].enable;
		end
		case (stateFf)
			sct_pkg::ST_IDLE: begin
				if (ctrlFf.scanEn && cur.enable && tick) begin
					nxt_state  = sct_pkg::ST_ACQ;
					nxt_cnt    = (acqFf[cur.acqSel] < sct_pkg::ACQ_MIN) ? sct_pkg::ACQ_MIN
						: acqFf[cur.acqSel];
					nxt_sample = 1'b1;
				end else if (anyEn && !cur.enable) begin
					nxt_ch = $clog2(NCH)'(chFf + 1'b1);
				end
			end
			sct_pkg::ST_ACQ: begin
				if (tick) begin
					nxt_cnt = cntFf - 10'h001;
					if (cntFf == 10'h001) begin
						nxt_state   = sct_pkg::ST_CONV;
						nxt_cnt     = 10'(resLen + sct_pkg::CONV_EXTRA);
						nxt_sample  = 1'b0;
						nxt_acqDone = 1'b1;
					end
				end
			end
			sct_pkg::ST_CONV: begin
				if (tick) begin
					nxt_cnt = cntFf - 10'h001;
					// strobe only after the first converter clock of the phase
					nxt_soc = (cntFf == 10'(resLen + sct_pkg::CONV_EXTRA));
					if (cntFf == 10'h001) begin
						nxt_resValid = 1'b1;
						nxt_result   = fmtCode(coreCode, resLen,
							!cur.diff && cur.negSel == sct_pkg::NEG_VSSA,
							cur.diff ? ctrlFf.signedDiff : ctrlFf.signedSe, ctrlFf.leftAlign);
						nxt_fmt      = {!cur.diff && cur.negSel == sct_pkg::NEG_VSSA,
							cur.diff ? ctrlFf.signedDiff : ctrlFf.signedSe,
							ctrlFf.leftAlign, resLen == sct_pkg::RES_LOW};
						nxt_ch       = $clog2(NCH)'(chFf + 1'b1);
						nxt_state    = sct_pkg::ST_IDLE;
					end
				end
			end
			default: nxt_state = sct_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			stateFf       <= sct_pkg::ST_IDLE;
			cntFf         <= '0;
			chFf          <= '0;
			fmtFf         <= '0;
			resultData    <= '0;
			sampleConnect <= 1'b0;
			socStrobe     <= 1'b0;
			acqDone       <= 1'b0;
			resultValid   <= 1'b0;
			routerSw      <= '0;
		end else begin
			stateFf       <= nxt_state;
			cntFf         <= nxt_cnt;
			chFf          <= nxt_ch;
			fmtFf         <= nxt_fmt;
			resultData    <= nxt_result;
			sampleConnect <= nxt_sample;
			socStrobe     <= nxt_soc;
			acqDone       <= nxt_acqDone;
			resultValid   <= nxt_resValid;
			routerSw      <= nxt_router;
		end
	end

	// bus slave: address and data taken in either order, one write at a time
	// only a beat that is taken now or held counts, so a stale address is never written
	assign doWrite = (awHeldFf || (s_axi_awvalid && s_axi_awready))
		&& (wHeldFf || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
	always_comb begin
		nxt_ctrl   = ctrlFf;
		nxt_acq    = acqFf;
		nxt_chan   = chanFf;
		nxt_hwOwn  = hwOwnFf;
		nxt_fwSw   = fwSwFf;
		nxt_awAddr = s_axi_awready && s_axi_awvalid ? s_axi_awaddr : awAddrFf;
		nxt_wData  = s_axi_wready && s_axi_wvalid ? s_axi_wdata : wDataFf;
		nxt_awHeld = awHeldFf | (s_axi_awready & s_axi_awvalid);
		nxt_wHeld  = wHeldFf | (s_axi_wready & s_axi_wvalid);
		nxt_bvalid = s_axi_bvalid & ~s_axi_bready;
		nxt_bresp  = s_axi_bresp;
		wrHit      = 1'b1;
		if (doWrite) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld  = 1'b0;
			nxt_bvalid = 1'b1;
			case (nxt_awAddr)
				sct_pkg::OFF_CTRL:     nxt_ctrl = nxt_wData[15:0];
				sct_pkg::OFF_ACQ_LOW: begin
					nxt_acq[0] = nxt_wData[9:0];
					nxt_acq[1] = nxt_wData[sct_pkg::ACQ_HI_POS +: 10];
				end
				sct_pkg::OFF_ACQ_HIGH: begin
					nxt_acq[2] = nxt_wData[9:0];
					nxt_acq[3] = nxt_wData[sct_pkg::ACQ_HI_POS +: 10];
				end
				sct_pkg::OFF_HW_OWN:   nxt_hwOwn = nxt_wData[15:0];
				sct_pkg::OFF_FW_SW:    nxt_fwSw  = nxt_wData[15:0];
				sct_pkg::OFF_STATUS, sct_pkg::OFF_RESULT: wrHit = 1'b1;
				default: begin
					wrHit = 1'b0;
					for (int i = 0; i < NCH; i++) begin
						if (nxt_awAddr == 8'(sct_pkg::OFF_CHAN + 8'(4 * i))) begin
							nxt_chan[i] = nxt_wData[9:0];
							wrHit = 1'b1;
						end
					end
				end
			endcase
			nxt_bresp = wrHit ? sct_pkg::RESP_OKAY : sct_pkg::RESP_SLVERR;
		end
	end

	// read side answers one cycle after the address is taken
	always_comb begin
		nxt_rvalid = s_axi_rvalid & ~s_axi_rready;
		nxt_rdata  = s_axi_rdata;
		nxt_rresp  = s_axi_rresp;
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = sct_pkg::RESP_OKAY;
			case (s_axi_araddr)
				sct_pkg::OFF_CTRL:     nxt_rdata = {16'h0000, ctrlFf};
				sct_pkg::OFF_ACQ_LOW:  nxt_rdata = {6'h00, acqFf[1], 6'h00, acqFf[0]};
				sct_pkg::OFF_ACQ_HIGH: nxt_rdata = {6'h00, acqFf[3], 6'h00, acqFf[2]};
				sct_pkg::OFF_HW_OWN:   nxt_rdata = {16'h0000, hwOwnFf};
				sct_pkg::OFF_FW_SW:    nxt_rdata = {16'h0000, fwSwFf};
				sct_pkg::OFF_STATUS:   nxt_rdata = {20'h00000, 4'(chFf), 6'h00, stateFf};
				sct_pkg::OFF_RESULT:   nxt_rdata = {16'h0000, resultData};
				default: begin
					nxt_rdata = 32'h0000_0000;
					nxt_rresp = sct_pkg::RESP_SLVERR;
					for (int i = 0; i < NCH; i++) begin
						if (s_axi_araddr == 8'(sct_pkg::OFF_CHAN + 8'(4 * i))) begin
							nxt_rdata = {22'h000000, chanFf[i]};
							nxt_rresp = sct_pkg::RESP_OKAY;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ctrlFf        <= sct_pkg::RST_CTRL[15:0];
			for (int i = 0; i < 4; i++) begin
				acqFf[i] <= sct_pkg::RST_ACQ;
			end
			for (int i = 0; i < NCH; i++) begin
				chanFf[i] <= '0;
			end
			hwOwnFf       <= sct_pkg::RST_HW_OWN;
			fwSwFf        <= sct_pkg::RST_FW_SW;
			awAddrFf      <= '0;
			wDataFf       <= '0;
			awHeldFf      <= 1'b0;
			wHeldFf       <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= '0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= '0;
		end else begin
			ctrlFf        <= nxt_ctrl;
			acqFf         <= nxt_acq;
			chanFf        <= nxt_chan;
			hwOwnFf       <= nxt_hwOwn;
			fwSwFf        <= nxt_fwSw;
			awAddrFf      <= nxt_awAddr;
			wDataFf       <= nxt_wData;
			awHeldFf      <= nxt_awHeld;
			wHeldFf       <= nxt_wHeld;
			s_axi_awready <= !nxt_awHeld && !nxt_bvalid && !(s_axi_awready && s_axi_awvalid);
			s_axi_wready  <= !nxt_wHeld && !nxt_bvalid && !(s_axi_wready && s_axi_wvalid);
			s_axi_bvalid  <= nxt_bvalid;
			s_axi_bresp   <= nxt_bresp;
			s_axi_arready <= !nxt_rvalid && !(s_axi_arready && s_axi_arvalid);
			s_axi_rvalid  <= nxt_rvalid;
			s_axi_rdata   <= nxt_rdata;
			s_axi_rresp   <= nxt_rresp;
		end
	end

	// checks on the timing, the result encoding, the firmware routing and the write response
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	a_acq_done_hold: assert property (acqDone |-> !sampleConnect && stateFf == sct_pkg::ST_CONV)
		else $error("acquisition done without disconnect");
	a_conv_len: assert property (acqDone |-> cntFf == 10'(resLen + sct_pkg::CONV_EXTRA))
		else $error("conversion length wrong");
	a_soc_delay: assert property (socStrobe |-> cntFf == 10'(resLen + sct_pkg::CONV_EXTRA - 1'b1))
		else $error("start strobe not one clock into conversion");
	a_acq_min: assert property ($rose(sampleConnect) |-> cntFf >= sct_pkg::ACQ_MIN)
		else $error("acquisition below four clocks");
	a_vssa_range: assert property (resultValid && fmtFf[3]
		|-> (fmtFf[1] ? resultData[15] == 1'b0 : resultData <= 16'h07ff))
		else $error("vssa result out of range");
	a_sign_ext: assert property (resultValid && fmtFf[2] && !fmtFf[3] && !fmtFf[1]
		|-> resultData[15:12] == {4{resultData[11]}})
		else $error("signed result not extended");
	a_zero_ext: assert property (resultValid && !fmtFf[2] && !fmtFf[1]
		|-> resultData[15:12] == 4'h0)
		else $error("unsigned result not zero extended");
	a_left_zero: assert property (resultValid && fmtFf[1] && fmtFf[0] |-> resultData[7:0] == 8'h00)
		else $error("left aligned low bits not zero");
	a_fw_route: assert property (hwOwnFf == 16'h0000 ##1 hwOwnFf == 16'h0000
		|-> routerSw == $past(fwSwFf))
		else $error("firmware switch bits not applied");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");

	c_acq_done: cover property (acqDone);
	c_signed_res: cover property (resultValid && fmtFf[2]);
	c_low_res_left: cover property (resultValid && fmtFf[1] && fmtFf[0]);
	c_wrap: cover property (resultValid && chFf == '0);
endmodule : sct_conv_ctrl
`default_nettype wire

/* File: tb/sct_fabric_model.sv */
// far-side model: converter core result lines and fabric switch drive
`default_nettype none
module sct_fabric_model (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        socStrobe,
	input  wire logic        resultValid,
	input  wire logic [11:0] nextCode,
	input  wire logic [15:0] swReq,
	input  wire logic        ownReq,
	output logic      [11:0] coreCode,
	output logic      [15:0] fabricSw,
	output logic             fabricOwn
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        busy;
	logic [11:0] junk;
	// the code is only meaningful while converting; a changing pattern otherwise
	// keeps a design that samples too early or too late from passing by luck
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			junk <= 12'h5a5;
		end else begin
			junk <= ~junk;
			if (socStrobe)
				busy <= 1'b1;
			else if (resultValid)
				busy <= 1'b0;
		end
	end
	assign coreCode  = busy ? nextCode : junk;
	// fabric drives its own switch lines and ownership request
	assign fabricSw  = swReq;
	assign fabricOwn = ownReq;
endmodule : sct_fabric_model
`default_nettype wire

/* File: tb/sct_conv_ctrl_test.sv */
// self-checking bench for the conversion timing control block
`default_nettype none
module sct_conv_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock, rst_b;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [11:0] coreCode, nextCode;
	logic [15:0] fabricSw, swReq, routerSw, resultData, resVal, routeAcq;
	logic        fabricOwn, ownReq, sampleConnect, socStrobe, acqDone, resultValid, scPrev;
	int          badCount = 0;
	int          cmpCount = 0;
	int          cyc = 0;
	int          tRise, tFall, tAcq, tSoc, tRes;

	sct_conv_ctrl #(.NCH(4)) u_dut (
		.clock(clock), .rst_b(rst_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.coreCode(coreCode), .fabricSw(fabricSw), .fabricOwn(fabricOwn), .routerSw(routerSw),
		.sampleConnect(sampleConnect), .socStrobe(socStrobe), .acqDone(acqDone),
		.resultData(resultData), .resultValid(resultValid)
	);

	sct_fabric_model u_far (
		.clock(clock), .rst_b(rst_b), .socStrobe(socStrobe), .resultValid(resultValid),
		.nextCode(nextCode), .swReq(swReq), .ownReq(ownReq), .coreCode(coreCode),
		.fabricSw(fabricSw), .fabricOwn(fabricOwn)
	);

	// 50 MHz system clock
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// event stamps in system cycles, taken from pre-edge values
	always @(posedge clock) begin
		cyc <= cyc + 1;
		scPrev <= sampleConnect;
		if (sampleConnect === 1'b1 && scPrev !== 1'b1)
			tRise <= cyc;
		if (sampleConnect !== 1'b1 && scPrev === 1'b1)
			tFall <= cyc;
		if (acqDone === 1'b1) begin
			tAcq <= cyc;
			routeAcq <= routerSw;
		end
		if (socStrobe === 1'b1)
			tSoc <= cyc;
		if (resultValid === 1'b1) begin
			tRes <= cyc;
			resVal <= resultData;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			badCount++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one write; address and data offered together, each released once taken
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er = sct_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		chk({31'h0, s_axi_bvalid}, 32'h1);
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask : axiWr

	// one read, compared against the expected word and response
	task automatic rdChk(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er = sct_pkg::RESP_OKAY);
		int n;
		n = 0;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			n++;
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		chk({31'h0, s_axi_rvalid}, 32'h1);
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask : rdChk

	// one conversion on channel 0; scan is dropped during acquisition so it stops after it
	task automatic runConv(input logic [15:0] ctrl, input logic [9:0] chan,
			input logic [11:0] code, input int acq, input int res, input logic [15:0] ed);
		int n;
		int dv;
		n = 0;
		dv = (ctrl[15:8] == 8'h00) ? 1 : int'(ctrl[15:8]);
		nextCode <= code;
		axiWr(sct_pkg::OFF_CHAN, {22'h0, chan});
		axiWr(sct_pkg::OFF_CTRL, {16'h0, ctrl | 16'h0001});
		while (sampleConnect !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		axiWr(sct_pkg::OFF_CTRL, {16'h0, ctrl & 16'hfffe});
		while (resultValid !== 1'b1 && n < 6000) begin
			@(posedge clock);
			n++;
		end
		chk({31'h0, resultValid}, 32'h1);
		@(posedge clock);
		chk(32'(tAcq - tRise), 32'(acq * dv));
		chk(32'(tFall), 32'(tAcq));
		chk(32'(tSoc - tAcq), 32'(dv));
		chk(32'(tRes - tAcq), 32'((res + 2) * dv));
		chk({16'h0, resVal}, {16'h0, ed});
	endtask : runConv

	task automatic tRegs;
		rdChk(sct_pkg::OFF_CTRL, 32'h0000_0100);
		rdChk(sct_pkg::OFF_ACQ_LOW, 32'h0004_0004);
		rdChk(sct_pkg::OFF_ACQ_HIGH, 32'h0004_0004);
		rdChk(sct_pkg::OFF_HW_OWN, 32'h0000_ffff);
		rdChk(sct_pkg::OFF_FW_SW, 32'h0);
		rdChk(8'h1c, 32'h0, sct_pkg::RESP_SLVERR);
		axiWr(8'h1c, 32'hffff_ffff, sct_pkg::RESP_SLVERR);
		axiWr(sct_pkg::OFF_ACQ_LOW, 32'h000a_0004);
		axiWr(sct_pkg::OFF_ACQ_HIGH, 32'h03ff_0007);
		rdChk(sct_pkg::OFF_ACQ_HIGH, 32'h03ff_0007);
		$display("test registers done");
	endtask : tRegs

	// default timing, halved converter clock and all four duration slots
	task automatic tTiming;
		runConv(16'h0100, 10'h050, 12'habc, 4, 12, 16'h0abc);
		runConv(16'h0200, 10'h050, 12'h456, 4, 12, 16'h0456);
		runConv(16'h0100, 10'h051, 12'h001, 10, 12, 16'h0001);
		runConv(16'h0100, 10'h052, 12'h7ff, 7, 12, 16'h07ff);
		runConv(16'h0100, 10'h053, 12'h800, 1023, 12, 16'h0800);
		$display("test timing done");
	endtask : tTiming

	// alternate resolutions and result encodings
	task automatic tFormat;
		runConv(16'h0100, 10'h054, 12'h05a, 4, 8, 16'h005a);
		runConv(16'h0102, 10'h054, 12'h2aa, 4, 10, 16'h02aa);
		runConv(16'h0104, 10'h040, 12'hc00, 4, 12, 16'h0400);
		runConv(16'h0104, 10'h040, 12'h3ff, 4, 12, 16'h0000);
		runConv(16'h0104, 10'h050, 12'h123, 4, 12, 16'hf923);
		runConv(16'h0104, 10'h050, 12'h800, 4, 12, 16'h0000);
		runConv(16'h0104, 10'h050, 12'hfff, 4, 12, 16'h07ff);
		runConv(16'h0100, 10'h060, 12'hfff, 4, 12, 16'h0fff);
		runConv(16'h0108, 10'h058, 12'h000, 4, 12, 16'hf800);
		runConv(16'h0106, 10'h054, 12'h1ff, 4, 10, 16'hffff);
		runConv(16'h0110, 10'h054, 12'h0a5, 4, 8, 16'ha500);
		$display("test format done");
	endtask : tFormat

	// switch ownership between fabric, firmware and sequencer
	task automatic tRoute;
		swReq <= 16'h3c3c;
		ownReq <= 1'b1;
		axiWr(sct_pkg::OFF_FW_SW, 32'h0000_a5a5);
		axiWr(sct_pkg::OFF_HW_OWN, 32'h0000_00ff);
		repeat (2) @(posedge clock);
		chk({16'h0, routerSw}, 32'h0000_a53c);
		axiWr(sct_pkg::OFF_HW_OWN, 32'h0);
		repeat (2) @(posedge clock);
		chk({16'h0, routerSw}, 32'h0000_a5a5);
		ownReq <= 1'b0;
		axiWr(sct_pkg::OFF_FW_SW, 32'h0);
		axiWr(sct_pkg::OFF_HW_OWN, 32'h0000_ffff);
		runConv(16'h0100, 10'h1e0, 12'h800, 4, 12, 16'h0800);
		chk({16'h0, routeAcq}, 32'h0000_0408);
		$display("test routing done");
	endtask : tRoute

	// two enabled channels with a disabled one between: the gap is skipped, each routed in turn
	task automatic tScan;
		int n;
		n = 0;
		rdChk(sct_pkg::OFF_RESULT, 32'h0000_0800);
		axiWr(sct_pkg::OFF_CHAN + 8'h08, {22'h0, 10'h0d0});
		axiWr(sct_pkg::OFF_CHAN, {22'h0, 10'h050});
		axiWr(sct_pkg::OFF_CTRL, 32'h0000_0101);
		while (acqDone !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk({16'h0, routerSw}, 32'h0000_0001);
		@(posedge clock);
		while (acqDone !== 1'b1 && n < 3000) begin
			@(posedge clock);
			n++;
		end
		chk({16'h0, routerSw}, 32'h0000_0002);
		axiWr(sct_pkg::OFF_CTRL, 32'h0000_0100);
		rdChk(sct_pkg::OFF_STATUS, 32'h0000_0202);
		$display("test scan done");
	endtask : tScan

	task automatic testDone;
		$display("comparisons %0d mismatches %0d", cmpCount, badCount);
		if (badCount == 0 && cmpCount > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : testDone

	// main sequence: inputs settled at time zero, reset held for 8 cycles
	initial begin
		rst_b = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		nextCode = 12'h000;
		swReq = 16'h0000;
		ownReq = 1'b0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		tRegs();
		tTiming();
		tFormat();
		tRoute();
		tScan();
		testDone();
	end

	// watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (30000) @(posedge clock);
		badCount++;
		testDone();
	end
endmodule : sct_conv_ctrl_test
`default_nettype wire
